// ===== rtl/fsuc_top.sv
// Flash self-update controller: APB registers, write buffer, flash sequencer, serial programming port
// How it works
// - Page and write buffer both hold thirty-two 16-bit words.
// - Erase takes one page, write a full 32-word page, read one word.
// - Enabled flag goes high when the enable procedure completes.
// - Buffer accepts words only while the enabled flag is high.
// - Software sets write-start; it stays high as busy during the write.
// - Write-start clears itself when the write finishes.
// - Read needs read-enable set; read-start then begins a one-word read.
// - Read-start clears when the word is available.
// - Erase page comes from upper eight address bits; low five ignored.
// - Clear-buffer bit empties the buffer, then returns to zero.
// - Buffer maps onto the page named by upper eight address bits.
// - Writing data high byte loads high and low bytes as one word.
// - Each buffer load below the page's last word increments the flash address registers.
// - Address stops incrementing at the last word of the page.
// - Buffer clears automatically after a write finishes.
// - Serial programming moves data both ways on one pin, programmer clocks.
// - Writing data low byte only updates that register.
// - Software may clear the enabled flag but cannot set it.
// - Op select: 000 write, 001 erase, 011 read, 110 enable.
// - Trigger bit starts the enable timer and clears on expiry.
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module fsuc_top (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Flash array
   output logic fl_req,
   output logic [1:0] fl_op,
   output logic [12:0] fl_addr,
   output logic [15:0] fl_wdata,
   input wire logic fl_ack,
   input wire logic [15:0] fl_rdata,
   // Serial programming port
   input wire logic prog_serial_clock,
   input wire logic prog_serial_data_in,
   output logic prog_serial_data_out,
   output logic prog_serial_data_oe_n
);
   fsuc_pkg::fsuc_state_e state_reg;
   logic pready_reg, pslverr_reg, fl_req_reg;
   logic [31:0] prdata_reg;
   logic [1:0] fl_op_reg;
   logic [12:0] fl_addr_reg, far_reg;
   logic [15:0] fl_wdata_reg;
   logic erase_write_enabled_flag_reg, enable_procedure_trigger_reg, fwt_reg, read_function_enable_reg, frd_reg, clear_buffer_request_reg;
   logic [2:0] mode_reg;
   logic [7:0] fc1_reg, ept_cnt_reg, rd_val;
   logic [7:0] fd_reg [8];
   logic [15:0] wbuf_mem [fsuc_pkg::PAGE_WORDS];
   logic [4:0] wr_idx_reg;
   logic [2:0] pclk_s_reg, pdat_s_reg;
   logic pclk_lvl_reg, prog_out_reg, prog_oe_n_reg;
   logic [4:0] icp_cnt_reg;
   logic [15:0] icp_sh_reg;
   logic wr_en, wr_fc0, wr_first_data_high, buf_load, en_done, wr_fin, er_fin, rd_fin, buf_clr, icp_rise;

   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a[1:0] == 2'h0) && (a <= fsuc_pkg::OFS_FLASH_ADDRESS_HIGH || a[7:5] == fsuc_pkg::FD_BLOCK);
   endfunction

   // Writes take effect only at the edge where the access phase completes
   assign wr_en = psel & penable & pready_reg & pwrite & is_mapped(paddr);
   assign wr_fc0 = wr_en && paddr == fsuc_pkg::OFS_FC0;
   assign wr_first_data_high = wr_en && paddr == fsuc_pkg::OFS_FIRST_DATA_HIGH;
   assign buf_load = wr_first_data_high & erase_write_enabled_flag_reg & (state_reg == fsuc_pkg::ST_IDLE);
   assign en_done = enable_procedure_trigger_reg && ept_cnt_reg == fsuc_pkg::ENABLE_LAST;
   assign wr_fin = state_reg == fsuc_pkg::ST_WRITE && fl_ack && wr_idx_reg == fsuc_pkg::LAST_IDX;
   assign er_fin = state_reg == fsuc_pkg::ST_ERASE && fl_ack;
   assign rd_fin = state_reg == fsuc_pkg::ST_READ && fl_ack;
   assign buf_clr = state_reg == fsuc_pkg::ST_CLEAR || wr_fin;
   assign icp_rise = pclk_s_reg[1] == pclk_s_reg[2] && pclk_s_reg[2] && !pclk_lvl_reg;

   always_comb begin
      rd_val = fsuc_pkg::RST_BYTE;
      unique case (paddr)
         fsuc_pkg::OFS_FC0: rd_val = {erase_write_enabled_flag_reg, mode_reg, enable_procedure_trigger_reg, fwt_reg, read_function_enable_reg, frd_reg};
         fsuc_pkg::OFS_FC1: rd_val = fc1_reg;
         fsuc_pkg::OFS_FC2: rd_val = {7'h00, clear_buffer_request_reg};
         fsuc_pkg::OFS_FLASH_ADDRESS_LOW: rd_val = far_reg[7:0];
         fsuc_pkg::OFS_FLASH_ADDRESS_HIGH: rd_val = {3'h0, far_reg[12:8]};
         default: if (paddr[7:5] == fsuc_pkg::FD_BLOCK) rd_val = fd_reg[paddr[4:2]];
      endcase
   end

   // APB answer: one wait state, then ready with data or error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
      end else begin
         pready_reg <= psel & penable & ~pready_reg;
         pslverr_reg <= psel & penable & ~pready_reg & ~is_mapped(paddr);
         prdata_reg <= (psel & penable & ~pready_reg & ~pwrite) ? {24'h000000, rd_val} : 32'h00000000;
      end
   end

   // Control register 0
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         erase_write_enabled_flag_reg <= 1'b0;
         mode_reg <= fsuc_pkg::MODE_WRITE;
         enable_procedure_trigger_reg <= 1'b0;
         fwt_reg <= 1'b0;
         read_function_enable_reg <= 1'b0;
         frd_reg <= 1'b0;
      end else begin
         if (en_done) erase_write_enabled_flag_reg <= 1'b1;
         else if (wr_fc0 && !pwdata[fsuc_pkg::BIT_ERASE_WRITE_ENABLED_FLAG]) erase_write_enabled_flag_reg <= 1'b0;
         if (wr_fc0) begin
            mode_reg <= pwdata[fsuc_pkg::MOD_HI:fsuc_pkg::MOD_LO];
            read_function_enable_reg <= pwdata[fsuc_pkg::BIT_READ_FUNCTION_ENABLE];
         end
         // Trigger only counts while the enable code is selected
         if (wr_fc0 && pwdata[fsuc_pkg::BIT_ENABLE_PROCEDURE_TRIGGER]
             && pwdata[fsuc_pkg::MOD_HI:fsuc_pkg::MOD_LO] == fsuc_pkg::MODE_ENABLE) enable_procedure_trigger_reg <= 1'b1;
         else if (en_done) enable_procedure_trigger_reg <= 1'b0;
         // Start is refused unless idle, enabled and a write or erase code is given
         if (wr_fc0 && pwdata[fsuc_pkg::BIT_FWT] && state_reg == fsuc_pkg::ST_IDLE && erase_write_enabled_flag_reg
             && (pwdata[fsuc_pkg::MOD_HI:fsuc_pkg::MOD_LO] == fsuc_pkg::MODE_WRITE
             || pwdata[fsuc_pkg::MOD_HI:fsuc_pkg::MOD_LO] == fsuc_pkg::MODE_ERASE)) fwt_reg <= 1'b1;
         else if (wr_fin || er_fin) fwt_reg <= 1'b0;
         if (wr_fc0 && pwdata[fsuc_pkg::BIT_FRD] && pwdata[fsuc_pkg::BIT_READ_FUNCTION_ENABLE] && state_reg == fsuc_pkg::ST_IDLE
             && pwdata[fsuc_pkg::MOD_HI:fsuc_pkg::MOD_LO] == fsuc_pkg::MODE_READ) frd_reg <= 1'b1;
         else if (rd_fin) frd_reg <= 1'b0;
      end
   end

   // Enable procedure timer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ept_cnt_reg <= 8'h00;
      else if (enable_procedure_trigger_reg && !en_done) ept_cnt_reg <= ept_cnt_reg + 8'h01;
      else ept_cnt_reg <= 8'h00;
   end

   // Plain registers, clear-buffer request and data bytes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fc1_reg <= fsuc_pkg::RST_BYTE;
         clear_buffer_request_reg <= 1'b0;
         for (int i = 0; i < 8; i++) fd_reg[i] <= fsuc_pkg::RST_BYTE;
      end else begin
         if (wr_en && paddr == fsuc_pkg::OFS_FC1) fc1_reg <= pwdata[7:0];
         // A new request in the clearing cycle wins and asks for another clear
         if (wr_en && paddr == fsuc_pkg::OFS_FC2 && pwdata[fsuc_pkg::BIT_CLEAR_BUFFER_REQUEST]) clear_buffer_request_reg <= 1'b1;
         else if (state_reg == fsuc_pkg::ST_CLEAR) clear_buffer_request_reg <= 1'b0;
         if (wr_en && paddr[7:5] == fsuc_pkg::FD_BLOCK) fd_reg[paddr[4:2]] <= pwdata[7:0];
         if (rd_fin) begin
            fd_reg[0] <= fl_rdata[7:0];
            fd_reg[1] <= fl_rdata[15:8];
         end
      end
   end

   // Flash address: software loads it, buffer loads walk it within the page
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) far_reg <= 13'h0000;
      else if (wr_en && paddr == fsuc_pkg::OFS_FLASH_ADDRESS_LOW) far_reg[7:0] <= pwdata[7:0];
      else if (wr_en && paddr == fsuc_pkg::OFS_FLASH_ADDRESS_HIGH) far_reg[12:8] <= pwdata[4:0];
      else if (buf_load && far_reg[4:0] != fsuc_pkg::LAST_IDX) far_reg <= far_reg + 13'h0001;
   end

   // Write buffer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < fsuc_pkg::PAGE_WORDS; i++) wbuf_mem[i] <= fsuc_pkg::CLEAR_WORD;
      end else if (buf_clr) begin
         for (int i = 0; i < fsuc_pkg::PAGE_WORDS; i++) wbuf_mem[i] <= fsuc_pkg::CLEAR_WORD;
      end else if (buf_load) begin
         wbuf_mem[far_reg[4:0]] <= {pwdata[7:0], fd_reg[0]};
      end
   end

   // Sequencer towards the flash array; request held until acknowledged
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= fsuc_pkg::ST_IDLE;
         fl_req_reg <= 1'b0;
         fl_op_reg <= fsuc_pkg::FOP_WRITE;
         fl_addr_reg <= 13'h0000;
         fl_wdata_reg <= 16'h0000;
         wr_idx_reg <= 5'h00;
      end else begin
         unique case (state_reg)
            fsuc_pkg::ST_IDLE: begin
               wr_idx_reg <= 5'h00;
               if (fwt_reg) begin
                  fl_req_reg <= 1'b1;
                  fl_addr_reg <= {far_reg[12:5], 5'h00};
                  fl_wdata_reg <= wbuf_mem[0];
                  if (mode_reg == fsuc_pkg::MODE_ERASE) begin
                     state_reg <= fsuc_pkg::ST_ERASE;
                     fl_op_reg <= fsuc_pkg::FOP_ERASE;
                  end else begin
                     state_reg <= fsuc_pkg::ST_WRITE;
                     fl_op_reg <= fsuc_pkg::FOP_WRITE;
                  end
               end else if (frd_reg) begin
                  state_reg <= fsuc_pkg::ST_READ;
                  fl_req_reg <= 1'b1;
                  fl_op_reg <= fsuc_pkg::FOP_READ;
                  fl_addr_reg <= far_reg;
               end else if (clear_buffer_request_reg) begin
                  state_reg <= fsuc_pkg::ST_CLEAR;
               end
            end
            fsuc_pkg::ST_WRITE: begin
               if (fl_ack) begin
                  if (wr_fin) begin
                     state_reg <= fsuc_pkg::ST_IDLE;
                     fl_req_reg <= 1'b0;
                  end else begin
                     wr_idx_reg <= wr_idx_reg + 5'h01;
                     fl_addr_reg <= fl_addr_reg + 13'h0001;
                     fl_wdata_reg <= wbuf_mem[wr_idx_reg + 5'h01];
                  end
               end
            end
            fsuc_pkg::ST_ERASE, fsuc_pkg::ST_READ: begin
               if (fl_ack) begin
                  state_reg <= fsuc_pkg::ST_IDLE;
                  fl_req_reg <= 1'b0;
               end
            end
            fsuc_pkg::ST_CLEAR: state_reg <= fsuc_pkg::ST_IDLE;
         endcase
      end
   end

   // Serial programming: 16 bits shifted in, then echoed back while driving the pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pclk_s_reg <= 3'h0;
         pdat_s_reg <= 3'h0;
         pclk_lvl_reg <= 1'b0;
         icp_cnt_reg <= 5'h00;
         icp_sh_reg <= 16'h0000;
         prog_out_reg <= 1'b0;
         prog_oe_n_reg <= 1'b1;
      end else begin
         pclk_s_reg <= {pclk_s_reg[1:0], prog_serial_clock};
         pdat_s_reg <= {pdat_s_reg[1:0], prog_serial_data_in};
         if (pclk_s_reg[1] == pclk_s_reg[2]) pclk_lvl_reg <= pclk_s_reg[2];
         if (icp_rise) begin
            icp_cnt_reg <= icp_cnt_reg + 5'h01;
            icp_sh_reg <= {icp_sh_reg[14:0], icp_cnt_reg[4] ? 1'b0 : pdat_s_reg[2]};
         end
         prog_out_reg <= icp_sh_reg[15];
         prog_oe_n_reg <= ~icp_cnt_reg[4];
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign fl_req = fl_req_reg;
   assign fl_op = fl_op_reg;
   assign fl_addr = fl_addr_reg;
   assign fl_wdata = fl_wdata_reg;
   assign prog_serial_data_out = prog_out_reg;
   assign prog_serial_data_oe_n = prog_oe_n_reg;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_FWT_CLEARS: assert property (wr_fin |=> !fwt_reg && fl_req == 1'b0) else $error("write busy not cleared");
   AST_FRD_DATA: assert property (rd_fin |=> !frd_reg && fd_reg[1] == $past(fl_rdata[15:8])) else $error("read not done");
   AST_NO_LOAD_OFF: assert property (wr_first_data_high && !erase_write_enabled_flag_reg |=> far_reg == $past(far_reg)) else $error("load while disabled");
   AST_ADDR_INC: assert property (buf_load && far_reg[4:0] != 5'h1F |=> far_reg == $past(far_reg) + 13'h0001) else $error("no increment");
   AST_ADDR_HOLD: assert property (buf_load && far_reg[4:0] == 5'h1F |=> far_reg == $past(far_reg)) else $error("page end passed");
   AST_LOAD_WORD: assert property (buf_load |=> wbuf_mem[$past(far_reg[4:0])] == {$past(pwdata[7:0]), $past(fd_reg[0])}) else $error("bad buffer word");
   AST_ERASE_WRITE_ENABLED_FLAG_SW: assert property (wr_fc0 && pwdata[7] && !erase_write_enabled_flag_reg && !en_done |=> !erase_write_enabled_flag_reg) else $error("software set enable");
   AST_ENABLE_TIME: assert property ($rose(enable_procedure_trigger_reg) |-> ##100 (erase_write_enabled_flag_reg && !enable_procedure_trigger_reg)) else $error("enable timing");
   AST_ERASE_PAGE: assert property (fl_req && fl_op == 2'h1 |-> fl_addr[4:0] == 5'h00 && fl_addr[12:5] == far_reg[12:5]) else $error("erase page");
   AST_BUF_AUTOCLR: assert property (wr_fin |=> wbuf_mem[0] == 16'h0000 && wbuf_mem[31] == 16'h0000) else $error("buffer kept");
   AST_CLEAR_BUFFER_REQUEST_DONE: assert property (state_reg == fsuc_pkg::ST_CLEAR && !(wr_en && paddr == 8'h08) |=> !clear_buffer_request_reg) else $error("clear bit stuck");

   COV_WRITE: cover property (wr_fin);
   COV_ERASE: cover property (er_fin);
   COV_READ: cover property (rd_fin);
   COV_ENABLE: cover property (en_done);
   COV_ICP_DRIVE: cover property ($fell(prog_serial_data_oe_n));
endmodule
`default_nettype wire

// ===== shared/fsuc_pkg.sv
// Constants and types for the flash self-update controller
package fsuc_pkg;
   // Geometry
   localparam int PAGE_WORDS = 32;
   localparam int WORD_W = 16;
   localparam int ADDR_W = 13;
   localparam int IDX_W = 5;
   localparam logic [4:0] LAST_IDX = 5'h1F;
   // Register byte offsets
   localparam logic [7:0] OFS_FC0 = 8'h00;
   localparam logic [7:0] OFS_FC1 = 8'h04;
   localparam logic [7:0] OFS_FC2 = 8'h08;
   localparam logic [7:0] OFS_FLASH_ADDRESS_LOW = 8'h0C;
   localparam logic [7:0] OFS_FLASH_ADDRESS_HIGH = 8'h10;
   localparam logic [7:0] OFS_FIRST_DATA_LOW = 8'h20;
   localparam logic [7:0] OFS_FIRST_DATA_HIGH = 8'h24;
   localparam logic [7:0] OFS_FD3H = 8'h3C;
   localparam logic [2:0] FD_BLOCK = 3'h1;
   // Control register 0 and 2 field positions
   localparam int BIT_ERASE_WRITE_ENABLED_FLAG = 7;
   localparam int MOD_HI = 6;
   localparam int MOD_LO = 4;
   localparam int BIT_ENABLE_PROCEDURE_TRIGGER = 3;
   localparam int BIT_FWT = 2;
   localparam int BIT_READ_FUNCTION_ENABLE = 1;
   localparam int BIT_FRD = 0;
   localparam int BIT_CLEAR_BUFFER_REQUEST = 0;
   // Operation select codes
   localparam logic [2:0] MODE_WRITE = 3'h0;
   localparam logic [2:0] MODE_ERASE = 3'h1;
   localparam logic [2:0] MODE_READ = 3'h3;
   localparam logic [2:0] MODE_ENABLE = 3'h6;
   // Flash array command codes
   localparam logic [1:0] FOP_WRITE = 2'h0;
   localparam logic [1:0] FOP_ERASE = 2'h1;
   localparam logic [1:0] FOP_READ = 2'h2;
   // Reset and cleared values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] CLEAR_WORD = 16'h0000;
   // Timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int ENABLE_TIME_US = 10;
   localparam int ENABLE_CYCLES = (ENABLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] ENABLE_LAST = 8'(ENABLE_CYCLES - 1);
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_ERASE = 5'h02,
      ST_WRITE = 5'h04,
      ST_READ = 5'h08,
      ST_CLEAR = 5'h10
   } fsuc_state_e;
endpackage

// ===== tb/fsuc_flash_model.sv
// Behavioural flash array answering the controller's requests
`timescale 1ns/1ns
`default_nettype none
module fsuc_flash_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Request side
   input wire logic fl_req,
   input wire logic [1:0] fl_op,
   input wire logic [12:0] fl_addr,
   input wire logic [15:0] fl_wdata,
   output logic fl_ack,
   output logic [15:0] fl_rdata,
   // Bench control and observation
   input wire logic slow,
   output logic [1:0] last_op,
   output logic [12:0] last_addr,
   output int n_writes
);
   logic [15:0] mem [0:8191];
   logic [1:0] wait_reg;
   // Non-blank start so an erase shows
   initial begin
      for (int i = 0; i < 8192; i++) begin
         mem[i] = 16'h5A5A ^ 16'(i);
      end
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fl_ack <= 1'b0;
         wait_reg <= 2'h0;
         fl_rdata <= 16'hA5C3;
         last_op <= 2'h3;
         last_addr <= 13'h0000;
         n_writes <= 0;
      end else if (fl_ack) begin
         fl_ack <= 1'b0;
         wait_reg <= 2'h0;
         // Read data is only good with ack; scramble it afterwards
         fl_rdata <= ~fl_rdata;
      end else if (fl_req && wait_reg == (slow ? 2'h3 : 2'h0)) begin
         fl_ack <= 1'b1;
         last_op <= fl_op;
         last_addr <= fl_addr;
         case (fl_op)
            fsuc_pkg::FOP_ERASE: begin
               for (int j = 0; j < 32; j++) begin
                  mem[{fl_addr[12:5], 5'(j)}] <= 16'hFFFF;
               end
            end
            fsuc_pkg::FOP_WRITE: begin
               mem[fl_addr] <= fl_wdata;
               n_writes <= n_writes + 1;
            end
            default: begin
               fl_rdata <= mem[fl_addr];
            end
         endcase
      end else begin
         fl_rdata <= ~fl_rdata;
         if (fl_req) begin
            wait_reg <= wait_reg + 2'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the flash self-update controller
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, slow;
   logic prog_clk, prog_dat, prog_out, prog_oe_n;
   logic fl_req, fl_ack;
   logic [7:0] paddr, rd, pg, lo, hi;
   logic [31:0] pwdata, prdata, seed;
   logic [1:0] fl_op, last_op;
   logic [12:0] fl_addr, last_addr;
   logic [15:0] fl_wdata, fl_rdata;
   logic [15:0] exp_w [0:31];
   int n_writes, n_errors, n_checks, n0, ix;
   fsuc_top u_fsuc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fl_req(fl_req),
      .fl_op(fl_op), .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_ack(fl_ack), .fl_rdata(fl_rdata),
      .prog_serial_clock(prog_clk), .prog_serial_data_in(prog_dat), .prog_serial_data_out(prog_out),
      .prog_serial_data_oe_n(prog_oe_n));
   fsuc_flash_model u_fsuc_flash_model (.pclk(pclk), .presetn(presetn), .fl_req(fl_req), .fl_op(fl_op),
      .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_ack(fl_ack), .fl_rdata(fl_rdata), .slow(slow),
      .last_op(last_op), .last_addr(last_addr), .n_writes(n_writes));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   function automatic logic [7:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   function automatic logic [15:0] memw(input logic [7:0] p, input int i);
      return u_fsuc_flash_model.mem[{p, 5'(i)}];
   endfunction
   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] want);
      n_checks++;
      if (got !== want) begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, want);
      end
   endtask
   // Holds the request until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 16) begin
         chk(16'h0000, 16'h0001);
         final_report();
      end
   endtask
   task automatic poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] want);
      int k;
      k = 0;
      do begin
         apb(1'b0, a, 8'h00);
         k++;
      end while ((rd & m) !== want && k < 200);
      chk({8'h00, rd & m}, {8'h00, want});
      if (k >= 200) begin
         final_report();
      end
   endtask
   task automatic set_addr(input logic [7:0] p, input logic [4:0] w);
      apb(1'b1, fsuc_pkg::OFS_FLASH_ADDRESS_HIGH, {3'h0, p[7:3]});
      apb(1'b1, fsuc_pkg::OFS_FLASH_ADDRESS_LOW, {p[2:0], w});
   endtask
   task automatic enable();
      apb(1'b1, fsuc_pkg::OFS_FC0, 8'h68);
      poll(fsuc_pkg::OFS_FC0, 8'h80, 8'h80);
      chk({8'h00, rd}, 16'h00E0);
   endtask
   // Programmer side: 16 bits in MSB first, then 16 clocks reading the echo before each rise
   task automatic serial_frame(input logic [15:0] w);
      for (int b = 0; b < 32; b++) begin
         prog_dat <= (b < 16) & w[4'(15 - b)];
         repeat (6) @(posedge pclk);
         if (b >= 16) begin
            chk({15'h0000, prog_oe_n}, 16'h0000);
            chk({15'h0000, prog_out}, {15'h0000, w[4'(31 - b)]});
         end
         prog_clk <= 1'b1;
         repeat (6) @(posedge pclk);
         prog_clk <= 1'b0;
      end
      repeat (8) @(posedge pclk);
      chk({15'h0000, prog_oe_n}, 16'h0001);
   endtask
   task automatic go(input logic [7:0] fc0);
      apb(1'b1, fsuc_pkg::OFS_FC0, fc0);
      poll(fsuc_pkg::OFS_FC0, 8'h05, 8'h00);
   endtask
   initial begin
      repeat (100000) @(posedge pclk);
      chk(16'h0000, 16'h0001);
      final_report();
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata, slow, prog_clk, prog_dat} = '0;
      seed = 32'd41032;
      presetn = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, fsuc_pkg::OFS_FC0, 8'h00);
      chk({8'h00, rd}, 16'h0000);
      apb(1'b0, 8'h40, 8'h00);
      chk({15'h0000, err}, 16'h0001);
      apb(1'b1, fsuc_pkg::OFS_FIRST_DATA_LOW, 8'h55);
      apb(1'b1, fsuc_pkg::OFS_FIRST_DATA_HIGH, 8'h66);
      apb(1'b0, fsuc_pkg::OFS_FLASH_ADDRESS_LOW, 8'h00);
      chk({8'h00, rd}, 16'h0000);
      apb(1'b1, fsuc_pkg::OFS_FC0, 8'h04);
      apb(1'b0, fsuc_pkg::OFS_FC0, 8'h00);
      chk({8'h00, rd}, 16'h0000);
      $display("test refusals done");
      // Second frame shows the bit counter wrapping back to the receive phase
      for (int f = 0; f < 2; f++) begin
         hi = xs();
         lo = xs();
         serial_frame({hi, lo});
      end
      $display("test serial port done");
      for (int pass = 0; pass < 2; pass++) begin
         slow <= pass[0];
         enable();
         apb(1'b1, fsuc_pkg::OFS_FC0, 8'h00);
         apb(1'b1, fsuc_pkg::OFS_FC0, 8'h80);
         apb(1'b0, fsuc_pkg::OFS_FC0, 8'h00);
         chk({8'h00, rd}, 16'h0000);
         enable();
         // Reserved operation code with start set must leave the busy bit low
         apb(1'b1, fsuc_pkg::OFS_FC0, 8'hA4);
         apb(1'b0, fsuc_pkg::OFS_FC0, 8'h00);
         chk({8'h00, rd}, 16'h00A0);
         pg = xs();
         set_addr(pg, 5'h00);
         apb(1'b1, fsuc_pkg::OFS_FC2, 8'h01);
         poll(fsuc_pkg::OFS_FC2, 8'h01, 8'h00);
         for (int i = 0; i < 33; i++) begin
            ix = (i > 31) ? 31 : i;
            lo = (i > 31) ? lo : xs();
            hi = xs();
            apb(1'b1, fsuc_pkg::OFS_FIRST_DATA_LOW, lo);
            apb(1'b0, fsuc_pkg::OFS_FLASH_ADDRESS_LOW, 8'h00);
            chk({8'h00, rd}, {8'h00, pg[2:0], 5'(ix)});
            apb(1'b1, fsuc_pkg::OFS_FIRST_DATA_HIGH, hi);
            exp_w[ix] = {hi, lo};
            apb(1'b0, fsuc_pkg::OFS_FLASH_ADDRESS_LOW, 8'h00);
            chk({8'h00, rd}, {8'h00, pg[2:0], 5'((ix < 31) ? ix + 1 : 31)});
         end
         apb(1'b0, fsuc_pkg::OFS_FLASH_ADDRESS_HIGH, 8'h00);
         chk({8'h00, rd}, {11'h000, pg[7:3]});
         set_addr(pg, 5'(xs()));
         go(8'h94);
         chk({14'h0000, last_op}, {14'h0000, fsuc_pkg::FOP_ERASE});
         chk({8'h00, last_addr[12:5]}, {8'h00, pg});
         chk(memw(pg, 7), 16'hFFFF);
         n0 = n_writes;
         apb(1'b1, fsuc_pkg::OFS_FC0, 8'h84);
         apb(1'b0, fsuc_pkg::OFS_FC0, 8'h00);
         chk({8'h00, rd}, 16'h0084);
         poll(fsuc_pkg::OFS_FC0, 8'h04, 8'h00);
         chk(16'(n_writes - n0), 16'h0020);
         for (int i = 0; i < 32; i++) begin
            chk(memw(pg, i), exp_w[i]);
         end
         ix = xs() & 8'h1F;
         set_addr(pg, 5'(ix));
         apb(1'b1, fsuc_pkg::OFS_FC0, 8'hB1);
         apb(1'b0, fsuc_pkg::OFS_FC0, 8'h00);
         chk({8'h00, rd}, 16'h00B0);
         go(8'hB3);
         apb(1'b0, fsuc_pkg::OFS_FIRST_DATA_LOW, 8'h00);
         lo = rd;
         apb(1'b0, fsuc_pkg::OFS_FIRST_DATA_HIGH, 8'h00);
         chk({rd, lo}, exp_w[ix]);
         go(8'h84);
         for (int i = 0; i < 32; i++) begin
            chk(memw(pg, i), 16'h0000);
         end
         set_addr(pg, 5'h00);
         apb(1'b1, fsuc_pkg::OFS_FIRST_DATA_LOW, xs());
         apb(1'b1, fsuc_pkg::OFS_FIRST_DATA_HIGH, 8'h7E);
         apb(1'b1, fsuc_pkg::OFS_FC2, 8'h01);
         poll(fsuc_pkg::OFS_FC2, 8'h01, 8'h00);
         go(8'h84);
         chk(memw(pg, 0), 16'h0000);
         $display("test page pass %0d done", pass);
      end
      final_report();
   end
endmodule
`default_nettype wire
